// file: fpc_pkg.sv
// Shared constants and types for the boot-sector flash host controller
package fpc_pkg;
    // Clock period and pin timing figures
    localparam int CLK_NS = 40;
    localparam int T_RP_NS = 500;
    localparam int T_WP_NS = 100;
    localparam int T_ACC_NS = 100;
    localparam int T_READY_NS = 20000;
    localparam int T_READY_NE_NS = 500;
    localparam int SYNC_STAGES = 2;

    // Cycle counts: least times round up, longest times round down
    localparam logic [15:0] RP_CYC = 16'((T_RP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] WP_CYC = 16'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] RD_CYC = 16'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES + 1);
    localparam logic [15:0] READY_CYC = 16'(T_READY_NS / CLK_NS);
    localparam logic [15:0] READY_NE_CYC = 16'((T_READY_NE_NS + CLK_NS - 1) / CLK_NS);

    // Command interface addresses and data
    localparam logic [18:0] UNLOCK_ADDR1 = 19'h00555;
    localparam logic [18:0] UNLOCK_ADDR2 = 19'h002AA;
    localparam logic [7:0] UNLOCK_DATA1 = 8'hAA;
    localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_IDENT = 8'h90;
    localparam logic [7:0] CMD_RESET = 8'hF0;

    // Address bit positions of the protect and identification cycles
    localparam int ADDR_SEL_BIT = 6;
    localparam logic [1:0] PROT_LOW_BITS = 2'b10;

    // Sector bookkeeping
    localparam int SECTORS = 11;
    localparam logic [10:0] PROT_ALL = 11'h7FF;
    localparam logic [10:0] PROT_NONE = 11'h000;
    localparam logic [3:0] TOP_SPLIT_BASE = 4'h7;
    localparam logic [3:0] BOT_BIG_BASE = 4'h3;

    typedef enum logic [2:0] {
        OP_READ,
        OP_WRITE,
        OP_PROGRAM,
        OP_IDENT,
        OP_HV_IDENT,
        OP_PROTECT,
        OP_UNPROTECT,
        OP_HW_RESET
    } fpc_op_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_RST_LOW,
        ST_RST_WAIT,
        ST_DONE
    } fpc_state_e;
endpackage

// file: fpc_sector_dec.sv
// Address to sector index decoder for top and bottom boot variants
`timescale 1ns/1ps
module fpc_sector_dec #(
    parameter bit TOP_BOOT = 1'b1
) (
    input wire logic [18:0] addr,
    output logic [3:0] sector_index
);
    always_comb begin
        sector_index = 4'h0;
        if (TOP_BOOT) begin
            if (addr[18:16] != 3'b111) begin
                sector_index = {1'b0, addr[18:16]};
            end else if (!addr[15]) begin
                sector_index = fpc_pkg::TOP_SPLIT_BASE;
            end else if (addr[14]) begin
                sector_index = 4'hA;
            end else begin
                sector_index = addr[13] ? 4'h9 : 4'h8;
            end
        end else begin
            if (addr[18:16] != 3'b000) begin
                sector_index = 4'({1'b0, addr[18:16]} + fpc_pkg::BOT_BIG_BASE);
            end else if (addr[15]) begin
                sector_index = fpc_pkg::BOT_BIG_BASE;
            end else if (!addr[14]) begin
                sector_index = 4'h0;
            end else begin
                sector_index = addr[13] ? 4'h2 : 4'h1;
            end
        end
    end
endmodule

// file: fpc_host_ctrl.sv
// Host controller driving a boot-sector parallel flash through its pins
// How it works
// - Host flags resets that interrupted program or erase, so user restarts them.
// - High voltage identify: A9 elevated, chip and output low, A6 low, A1:A0 pick.
// - Identification codes reachable in-system through the command sequence.
// - Protect uses elevated reset with bus writes; protect all before unprotect.
// - Host writes the reset command to leave in-system identification.
`timescale 1ns/1ps
module fpc_host_ctrl #(
    parameter bit TOP_BOOT = 1'b1
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire fpc_pkg::fpc_op_e cmd_op,
    input wire logic [18:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic [3:0] rsp_sector,
    output logic rsp_timeout,
    output logic rsp_interrupted,
    output logic rsp_refused,
    output logic [10:0] prot_done,
    output logic [18:0] flash_addr,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe_n,
    input wire logic [7:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_reset_n,
    output logic flash_reset_vid,
    output logic flash_a9_vid,
    input wire logic flash_ready_busy
);
    fpc_pkg::fpc_state_e state_reg;
    fpc_pkg::fpc_op_e op_reg;
    logic [18:0] addr_reg;
    logic [7:0] data_reg;
    logic [1:0] step_reg;
    logic [15:0] cnt_reg;
    logic [7:0] dq_s1_reg;
    logic [7:0] dq_s2_reg;
    logic rb_s1_reg;
    logic rb_s2_reg;
    logic [28:0] cur;
    logic cur_rd;
    logic cur_last;
    logic [3:0] sector;
    logic in_cycle;
    logic strobe_end;

    // One bus cycle of an operation: {is_read, last, address, data}
    function automatic logic [28:0] cycle_of(input fpc_pkg::fpc_op_e op, input logic [1:0] step,
                                             input logic [18:0] a, input logic [7:0] d);
        logic [18:0] a_lo6;
        a_lo6 = a;
        a_lo6[fpc_pkg::ADDR_SEL_BIT] = 1'b0;
        cycle_of = {2'b11, a, d};
        unique case (op)
            fpc_pkg::OP_READ: cycle_of = {2'b11, a, d};
            fpc_pkg::OP_WRITE: cycle_of = {2'b01, a, d};
            fpc_pkg::OP_PROGRAM, fpc_pkg::OP_IDENT: begin
                // unlock pair before every program or identify command
                unique case (step)
                    2'd0: cycle_of = {2'b00, fpc_pkg::UNLOCK_ADDR1, fpc_pkg::UNLOCK_DATA1};
                    2'd1: cycle_of = {2'b00, fpc_pkg::UNLOCK_ADDR2, fpc_pkg::UNLOCK_DATA2};
                    2'd2: cycle_of = {2'b00, fpc_pkg::UNLOCK_ADDR1,
                                      (op == fpc_pkg::OP_PROGRAM) ? fpc_pkg::CMD_PROGRAM
                                                                  : fpc_pkg::CMD_IDENT};
                    2'd3: begin
                        // in-system identify reads the code, then resets
                        if (op == fpc_pkg::OP_PROGRAM) begin
                            cycle_of = {2'b01, a, d};
                        end else begin
                            cycle_of = {2'b10, a, d};
                        end
                    end
                endcase
            end
            // high voltage identify forces A6 low
            fpc_pkg::OP_HV_IDENT: cycle_of = {2'b11, a_lo6, d};
            // protect cycle uses A6 low, A1 high, A0 low
            fpc_pkg::OP_PROTECT: cycle_of = {2'b01, a_lo6[18:2], fpc_pkg::PROT_LOW_BITS, d};
            fpc_pkg::OP_UNPROTECT: begin
                cycle_of = {2'b01, a[18:7], 1'b1, a[5:2], fpc_pkg::PROT_LOW_BITS, d};
            end
            fpc_pkg::OP_HW_RESET: cycle_of = {2'b01, a, d};
        endcase
    endfunction

    // Identify exit needs a fifth cycle beyond the two-bit step range
    logic ident_exit_reg;
    always_comb begin
        cur = cycle_of(op_reg, step_reg, addr_reg, data_reg);
        if (ident_exit_reg) begin
            cur = {2'b01, addr_reg, fpc_pkg::CMD_RESET};
        end
    end
    assign cur_rd = cur[28];
    assign cur_last = cur[27];
    assign in_cycle = (state_reg == fpc_pkg::ST_SETUP) || (state_reg == fpc_pkg::ST_STROBE)
                      || (state_reg == fpc_pkg::ST_HOLD);
    // strobes last whole cycles, far beyond the glitch filter
    assign strobe_end = cnt_reg == (cur_rd ? fpc_pkg::RD_CYC : fpc_pkg::WP_CYC) - 16'd1;
    assign cmd_ready = state_reg == fpc_pkg::ST_IDLE;
    assign rsp_valid = state_reg == fpc_pkg::ST_DONE;

    fpc_sector_dec #(.TOP_BOOT(TOP_BOOT)) u_dec (
        .addr(addr_reg),
        .sector_index(sector)
    );

    // Pin inputs cross two flip-flops
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            dq_s1_reg <= 8'h00;
            dq_s2_reg <= 8'h00;
            rb_s1_reg <= 1'b1;
            rb_s2_reg <= 1'b1;
        end else if (clk_en) begin
            dq_s1_reg <= flash_dq_in;
            dq_s2_reg <= dq_s1_reg;
            rb_s1_reg <= flash_ready_busy;
            rb_s2_reg <= rb_s1_reg;
        end
    end

    // Sequencer
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_reg <= fpc_pkg::ST_IDLE;
            op_reg <= fpc_pkg::OP_READ;
            addr_reg <= 19'h00000;
            data_reg <= 8'h00;
            step_reg <= 2'd0;
            cnt_reg <= 16'h0000;
            ident_exit_reg <= 1'b0;
        end else if (clk_en) begin
            unique case (state_reg)
                fpc_pkg::ST_IDLE: begin
                    if (cmd_valid) begin
                        op_reg <= cmd_op;
                        addr_reg <= cmd_addr;
                        data_reg <= cmd_data;
                        step_reg <= 2'd0;
                        cnt_reg <= 16'h0000;
                        ident_exit_reg <= 1'b0;
                        if (cmd_op == fpc_pkg::OP_HW_RESET) begin
                            state_reg <= fpc_pkg::ST_RST_LOW;
                        end else if (cmd_op == fpc_pkg::OP_UNPROTECT && prot_done != fpc_pkg::PROT_ALL) begin
                            // unprotect refused until every sector was protected
                            state_reg <= fpc_pkg::ST_DONE;
                        end else begin
                            state_reg <= fpc_pkg::ST_SETUP;
                        end
                    end
                end
                fpc_pkg::ST_SETUP: begin
                    cnt_reg <= 16'h0000;
                    state_reg <= fpc_pkg::ST_STROBE;
                end
                fpc_pkg::ST_STROBE: begin
                    cnt_reg <= cnt_reg + 16'd1;
                    if (strobe_end) begin
                        state_reg <= fpc_pkg::ST_HOLD;
                    end
                end
                fpc_pkg::ST_HOLD: begin
                    if (cur_last) begin
                        state_reg <= fpc_pkg::ST_DONE;
                    end else begin
                        if (step_reg == 2'd3) begin
                            ident_exit_reg <= 1'b1;
                        end
                        step_reg <= step_reg + 2'd1;
                        state_reg <= fpc_pkg::ST_SETUP;
                    end
                end
                fpc_pkg::ST_RST_LOW: begin
                    // hold reset low for the least pulse time
                    cnt_reg <= cnt_reg + 16'd1;
                    if (cnt_reg == fpc_pkg::RP_CYC - 16'd1) begin
                        cnt_reg <= 16'h0000;
                        state_reg <= fpc_pkg::ST_RST_WAIT;
                    end
                end
                fpc_pkg::ST_RST_WAIT: begin
                    // wait for ready, at least the idle recovery time
                    cnt_reg <= cnt_reg + 16'd1;
                    if ((rb_s2_reg && cnt_reg >= fpc_pkg::READY_NE_CYC - 16'd1)
                        || cnt_reg == fpc_pkg::READY_CYC - 16'd1) begin
                        state_reg <= fpc_pkg::ST_DONE;
                    end
                end
                fpc_pkg::ST_DONE: state_reg <= fpc_pkg::ST_IDLE;
                default: state_reg <= fpc_pkg::ST_IDLE;
            endcase
        end
    end

    // Answer fields
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rsp_data <= 8'h00;
            rsp_sector <= 4'h0;
            rsp_timeout <= 1'b0;
            rsp_interrupted <= 1'b0;
            rsp_refused <= 1'b0;
        end else if (clk_en) begin
            if (state_reg == fpc_pkg::ST_IDLE && cmd_valid) begin
                rsp_timeout <= 1'b0;
                // report that a running program or erase was cut short
                rsp_interrupted <= (cmd_op == fpc_pkg::OP_HW_RESET) && !rb_s2_reg;
                rsp_refused <= cmd_op == fpc_pkg::OP_UNPROTECT && prot_done != fpc_pkg::PROT_ALL;
            end
            if (state_reg == fpc_pkg::ST_STROBE && strobe_end && cur_rd) begin
                // array, identify and status reads from synchronised bus
                rsp_data <= dq_s2_reg;
            end
            if (state_reg == fpc_pkg::ST_HOLD) begin
                rsp_sector <= sector;
            end
            if (state_reg == fpc_pkg::ST_RST_WAIT && !rb_s2_reg
                && cnt_reg == fpc_pkg::READY_CYC - 16'd1) begin
                rsp_timeout <= 1'b1;
            end
        end
    end

    // shadow starts clear, pin reset keeps it
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            prot_done <= fpc_pkg::PROT_NONE;
        end else if (clk_en) begin
            // track protect writes per decoded sector
            if (state_reg == fpc_pkg::ST_HOLD && op_reg == fpc_pkg::OP_PROTECT) begin
                prot_done <= prot_done | 11'(11'h001 << sector);
            end
        end
    end

    // Flash pins, registered one cycle behind the sequencer
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            flash_addr <= 19'h00000;
            flash_dq_out <= 8'h00;
            flash_dq_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_reset_n <= 1'b1;
            flash_reset_vid <= 1'b0;
            flash_a9_vid <= 1'b0;
        end else if (clk_en) begin
            flash_addr <= in_cycle ? cur[26:8] : flash_addr;
            flash_dq_out <= in_cycle ? cur[7:0] : flash_dq_out;
            // write strobe only with chip select low and output gate high
            flash_ce_n <= !in_cycle;
            flash_we_n <= !(state_reg == fpc_pkg::ST_STROBE && !cur_rd);
            flash_oe_n <= !(state_reg == fpc_pkg::ST_STROBE && cur_rd);
            flash_dq_oe_n <= !((state_reg == fpc_pkg::ST_STROBE || state_reg == fpc_pkg::ST_HOLD)
                               && !cur_rd);
            // pin reset quiets the bus and clears flash modes
            flash_reset_n <= state_reg != fpc_pkg::ST_RST_LOW;
            // elevated reset only around protect cycles
            flash_reset_vid <= in_cycle && (op_reg == fpc_pkg::OP_PROTECT
                                            || op_reg == fpc_pkg::OP_UNPROTECT);
            // elevated A9 only for high voltage identify
            flash_a9_vid <= in_cycle && op_reg == fpc_pkg::OP_HV_IDENT;
        end
    end

    property p_reset_quiet;
        @(posedge sys_clk) disable iff (!nrst)
        !flash_reset_n |-> flash_ce_n && flash_we_n && flash_oe_n && flash_dq_oe_n;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("bus active during reset");

    property p_reset_len;
        @(posedge sys_clk) disable iff (!nrst)
        $fell(flash_reset_n) |-> !flash_reset_n [*8];
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset pulse too short");

    property p_write_gate;
        @(posedge sys_clk) disable iff (!nrst)
        !flash_we_n |-> !flash_ce_n && flash_oe_n && !flash_dq_oe_n;
    endproperty
    a_write_gate: assert property (p_write_gate) else $error("write strobe without gating");

    property p_we_width;
        @(posedge sys_clk) disable iff (!nrst)
        $fell(flash_we_n) |=> !flash_we_n;
    endproperty
    a_we_width: assert property (p_we_width) else $error("write pulse one cycle");

    property p_a9_read;
        @(posedge sys_clk) disable iff (!nrst)
        flash_a9_vid |-> flash_we_n && !flash_addr[fpc_pkg::ADDR_SEL_BIT] && flash_reset_n;
    endproperty
    a_a9_read: assert property (p_a9_read) else $error("A9 high voltage with bad pins");

    property p_unprot_refuse;
        @(posedge sys_clk) disable iff (!nrst)
        (cmd_ready && cmd_valid && clk_en && cmd_op == fpc_pkg::OP_UNPROTECT
         && prot_done != fpc_pkg::PROT_ALL) |=> rsp_valid && rsp_refused;
    endproperty
    a_unprot_refuse: assert property (p_unprot_refuse) else $error("unprotect not refused");

    property p_ready_done;
        @(posedge sys_clk) disable iff (!nrst)
        (rsp_valid && op_reg == fpc_pkg::OP_HW_RESET && !rsp_timeout) |-> $past(rb_s2_reg);
    endproperty
    a_ready_done: assert property (p_ready_done) else $error("reset done while busy");

    property p_ident_exit;
        @(posedge sys_clk) disable iff (!nrst)
        (rsp_valid && op_reg == fpc_pkg::OP_IDENT) |-> $past(flash_dq_out, 2) == fpc_pkg::CMD_RESET;
    endproperty
    a_ident_exit: assert property (p_ident_exit) else $error("identify left without reset");

    property p_vid_only_prot;
        @(posedge sys_clk) disable iff (!nrst)
        $rose(flash_reset_vid) |-> flash_reset_n && $past(op_reg == fpc_pkg::OP_PROTECT
                                                       || op_reg == fpc_pkg::OP_UNPROTECT);
    endproperty
    a_vid_only_prot: assert property (p_vid_only_prot) else $error("elevated reset misuse");

    c_program: cover property (@(posedge sys_clk) rsp_valid && op_reg == fpc_pkg::OP_PROGRAM);
    c_ident: cover property (@(posedge sys_clk) rsp_valid && op_reg == fpc_pkg::OP_IDENT);
    c_reset_int: cover property (@(posedge sys_clk) rsp_valid && rsp_interrupted);
    c_unprot: cover property (@(posedge sys_clk) rsp_valid && op_reg == fpc_pkg::OP_UNPROTECT
                                                 && !rsp_refused);
endmodule

// file: fpc_flash_model.sv
// Behavioural boot-sector flash device seen from its pins
`timescale 1ns/1ps
module fpc_flash_model #(
    // Identification values are arbitrary
    parameter logic [7:0] MAKER_CODE = 8'h1C,
    // part code of the top boot build
    parameter logic [7:0] PART_CODE = 8'h2D,
    parameter logic [7:0] CONT_CODE = 8'h3E
) (
    input wire logic [18:0] flash_addr,
    input wire logic [7:0] flash_dq_out,
    output logic [7:0] flash_dq_in,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic flash_dq_oe_n,
    input wire logic flash_reset_n,
    input wire logic flash_reset_vid,
    input wire logic flash_a9_vid,
    input wire logic hold_busy,
    output logic flash_ready_busy
);
    localparam logic [26:0] U1 = {fpc_pkg::UNLOCK_ADDR1, fpc_pkg::UNLOCK_DATA1};
    localparam logic [26:0] U2 = {fpc_pkg::UNLOCK_ADDR2, fpc_pkg::UNLOCK_DATA2};
    localparam logic [26:0] UP = {fpc_pkg::UNLOCK_ADDR1, fpc_pkg::CMD_PROGRAM};
    localparam logic [26:0] UI = {fpc_pkg::UNLOCK_ADDR1, fpc_pkg::CMD_IDENT};
    logic [7:0] mem [0:524287];
    // Erased array reads all ones
    initial for (int i = 0; i < 524288; i++) mem[i] = 8'hFF;
    // shipped clear and kept over reset
    logic [10:0] prot = 11'h000;
    logic [1:0] step = 2'd0;
    logic ident = 1'b0;
    logic busy = 1'b0;
    logic fell = 1'b0;
    logic [7:0] val;
    logic [7:0] last = 8'h00;
    logic [26:0] wr;
    logic [26:0] pend;
    time t_fall = 0;
    time t_start = 0;
    time t_rst = 0;
    wire drive = !flash_ce_n && !flash_oe_n && flash_reset_n;
    wire wcyc = !flash_ce_n && flash_oe_n && flash_reset_n && !flash_dq_oe_n;
    function automatic int sec(input logic [18:0] a);
        if (a[18:16] != 3'h7) return int'(a[18:16]);
        if (!a[15]) return 7;
        if (!a[14]) return a[13] ? 9 : 8;
        return 10;
    endfunction
    always @* begin
        case ({flash_a9_vid || ident, flash_addr[1:0]})
            3'b100: val = MAKER_CODE;
            3'b101: val = PART_CODE;
            3'b111: val = CONT_CODE;
            3'b110: val = {7'h00, prot[sec(flash_addr)]};
            default: val = mem[flash_addr];
        endcase
    end
    always @* begin
        if (drive) last = val;
    end
    // outputs float during reset; a released bus shows the inverse byte
    assign flash_dq_in = drive ? val : ~last;
    // busy while an algorithm runs, through the reset recovery that cut one short, or while hold_busy is set
    assign flash_ready_busy = !(busy || hold_busy);
    always @(negedge flash_we_n) begin
        fell = 1'b1;
        t_fall = $time;
    end
    always @(posedge flash_we_n) begin
        wr = {flash_addr, flash_dq_out};
        if (fell && wcyc && !busy && $time - t_fall >= 5) begin
            // protect cycles under the elevated reset level
            if (flash_reset_vid && flash_addr[1:0] == 2'b10) begin
                if (!flash_addr[6]) prot[sec(flash_addr)] = 1'b1;
                else prot = 11'h000;
            end else if (step == 2'd3) begin
                step = 2'd0;
                if (!prot[sec(flash_addr)] || flash_reset_vid) begin
                    pend = wr;
                    t_start = $time;
                    busy = 1'b1;
                end
            end else if (flash_dq_out == fpc_pkg::CMD_RESET) begin
                step = 2'd0;
                ident = 1'b0;
            end else if (wr == U1) step = 2'd1;
            else if (step == 2'd1 && wr == U2) step = 2'd2;
            else if (step == 2'd2 && wr == UP) step = 2'd3;
            else begin
                ident = step == 2'd2 && wr == UI;
                step = 2'd0;
            end
        end
    end
    // Commit only if no reset cut the algorithm short
    always @(posedge busy) begin
        #4000;
        if (t_rst < t_start) begin
            mem[pend[26:8]] = mem[pend[26:8]] & pend[7:0];
            busy = 1'b0;
        end
    end
    // reset drops any partial sequence or mode
    always @(negedge flash_reset_n) begin
        t_rst = $time;
        step = 2'd0;
        ident = 1'b0;
    end
    // longer recovery when an algorithm was running
    always @(posedge flash_reset_n) begin
        #(busy ? 2000 : 200);
        busy = 1'b0;
    end
endmodule

// file: testbench.sv
// Testbench for the flash host controller against the device model
`timescale 1ns/1ps
module testbench;
    localparam logic [18:0] BASE [11] = '{19'h00000, 19'h10000, 19'h20000, 19'h30000,
        19'h40000, 19'h50000, 19'h60000, 19'h70000, 19'h78000, 19'h7A000, 19'h7C000};
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic cmd_valid = 1'b0;
    logic hold_busy = 1'b0;
    fpc_pkg::fpc_op_e cmd_op = fpc_pkg::OP_READ;
    logic [18:0] cmd_addr = 19'h00000;
    logic [7:0] cmd_data = 8'h00;
    wire cmd_ready, rsp_valid, rsp_timeout, rsp_interrupted, rsp_refused, flash_dq_oe_n;
    wire flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, flash_reset_vid, flash_a9_vid;
    wire flash_ready_busy;
    wire [7:0] rsp_data, flash_dq_out, flash_dq_in;
    wire [3:0] rsp_sector;
    wire [10:0] prot_done;
    wire [18:0] flash_addr;
    int fail_count = 0;
    int total_checks = 0;
    fpc_host_ctrl #(.TOP_BOOT(1'b1)) dut (.sys_clk, .nrst, .clk_en, .cmd_valid, .cmd_ready,
        .cmd_op, .cmd_addr, .cmd_data, .rsp_valid, .rsp_data, .rsp_sector, .rsp_timeout,
        .rsp_interrupted, .rsp_refused, .prot_done, .flash_addr, .flash_dq_out, .flash_dq_oe_n,
        .flash_dq_in, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n, .flash_reset_vid,
        .flash_a9_vid, .flash_ready_busy);
    fpc_flash_model flash (.flash_addr, .flash_dq_out, .flash_dq_in, .flash_ce_n, .flash_oe_n,
        .flash_we_n, .flash_reset_n, .flash_reset_vid, .flash_a9_vid, .hold_busy,
        .flash_ready_busy, .flash_dq_oe_n);
    initial forever #20 sys_clk = ~sys_clk;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            fail_count++;
            wrap_up();
        end
    endtask
    // Request held until taken, then wait for the one-cycle answer
    task automatic do_op(input fpc_pkg::fpc_op_e op, input logic [18:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        do begin
            @(posedge sys_clk);
            #1;
            if (cmd_ready !== 1'b1) cmd_valid = 1'b0;
            n++;
        end while (rsp_valid !== 1'b1 && n < 2000);
        bound(n, 2000);
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (flash_ready_busy !== 1'b1 && n < 1000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        bound(n, 1000);
    endtask
    task automatic rd(input logic [18:0] a);
        do_op(fpc_pkg::OP_READ, a, 8'h00);
    endtask
    task automatic prog_chk(input logic [18:0] a, input logic [7:0] d, input logic [7:0] e);
        do_op(fpc_pkg::OP_PROGRAM, a, d);
        wait_ready();
        rd(a);
        check("program result", rsp_data, e);
    endtask
    task automatic t_array();
        rd(19'h12345);
        check("erased byte", rsp_data, 8'hFF);
        do_op(fpc_pkg::OP_WRITE, 19'h12345, 8'h00);
        rd(19'h12345);
        check("lone write", rsp_data, 8'hFF);
        prog_chk(19'h12345, 8'h5A, 8'h5A);
        for (int i = 0; i < 11; i++) begin
            rd(BASE[i] | 19'h01FFF);
            check("sector", rsp_sector, 32'(i));
        end
        $display("array test done");
    endtask
    task automatic t_ident();
        logic [7:0] e;
        for (int i = 0; i < 4; i++) begin
            e = i == 0 ? 8'h1C : i == 1 ? 8'h2D : i == 3 ? 8'h3E : 8'h00;
            do_op(fpc_pkg::OP_IDENT, 19'h7C000 | 19'(i), 8'h00);
            check("in-system id", rsp_data, e);
            do_op(fpc_pkg::OP_HV_IDENT, 19'h7C000 | 19'(i), 8'h00);
            check("high-voltage id", rsp_data, e);
        end
        rd(19'h12345);
        check("array after id", rsp_data, 8'h5A);
        $display("ident test done");
    endtask
    task automatic t_protect();
        do_op(fpc_pkg::OP_PROTECT, 19'h7C000, 8'h00);
        check("shadow", prot_done, 11'h400);
        do_op(fpc_pkg::OP_UNPROTECT, 19'h7C000, 8'h00);
        check("refused", rsp_refused, 1'b1);
        do_op(fpc_pkg::OP_HW_RESET, 19'h00000, 8'h00);
        do_op(fpc_pkg::OP_HV_IDENT, 19'h7C002, 8'h00);
        check("protected status", rsp_data, 8'h01);
        prog_chk(19'h7C100, 8'h00, 8'hFF);
        for (int i = 0; i < 11; i++) begin
            do_op(fpc_pkg::OP_PROTECT, BASE[i], 8'h00);
        end
        check("all protected", prot_done, 11'h7FF);
        do_op(fpc_pkg::OP_UNPROTECT, 19'h00000, 8'h00);
        check("accepted", rsp_refused, 1'b0);
        do_op(fpc_pkg::OP_HV_IDENT, 19'h7C002, 8'h00);
        check("unprotected status", rsp_data, 8'h00);
        prog_chk(19'h7C100, 8'h00, 8'h00);
        $display("protect test done");
    endtask
    task automatic t_reset();
        do_op(fpc_pkg::OP_HW_RESET, 19'h00000, 8'h00);
        check("idle reset", {rsp_interrupted, rsp_timeout}, 2'b00);
        do_op(fpc_pkg::OP_WRITE, fpc_pkg::UNLOCK_ADDR1, fpc_pkg::UNLOCK_DATA1);
        do_op(fpc_pkg::OP_WRITE, fpc_pkg::UNLOCK_ADDR2, fpc_pkg::UNLOCK_DATA2);
        do_op(fpc_pkg::OP_WRITE, fpc_pkg::UNLOCK_ADDR1, fpc_pkg::CMD_PROGRAM);
        do_op(fpc_pkg::OP_HW_RESET, 19'h00000, 8'h00);
        do_op(fpc_pkg::OP_WRITE, 19'h00100, 8'h00);
        rd(19'h00100);
        check("sequence dropped", rsp_data, 8'hFF);
        do_op(fpc_pkg::OP_PROGRAM, 19'h00200, 8'h0F);
        repeat (4) @(posedge sys_clk);
        #1;
        do_op(fpc_pkg::OP_HW_RESET, 19'h00000, 8'h00);
        check("busy reset", {rsp_interrupted, rsp_timeout}, 2'b10);
        wait_ready();
        rd(19'h00200);
        check("aborted", rsp_data, 8'hFF);
        prog_chk(19'h00200, 8'h0F, 8'h0F);
        hold_busy = 1'b1;
        // Let the synchroniser see busy before the reset is taken
        repeat (3) @(posedge sys_clk);
        #1;
        do_op(fpc_pkg::OP_HW_RESET, 19'h00000, 8'h00);
        check("stuck busy", {rsp_interrupted, rsp_timeout}, 2'b11);
        hold_busy = 1'b0;
        $display("reset test done");
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        t_array();
        t_ident();
        t_protect();
        t_reset();
        wrap_up();
    end
endmodule
